// ---- src/dmcfg_pkg.sv ----
// constants shared by the dram mode and chip-select config block
package dmcfg_pkg;

	// register byte addresses and widths
	localparam logic [7:0]  ADR_MODE      = 8'h7c;
	localparam logic [7:0]  ADR_REMAP     = 8'h80;
	localparam int          WB_ADR_W      = 8;

	// dram_mode_control field positions
	localparam int          RATE_LSB      = 8;
	localparam int          CMD_DIS_B_BIT = 7;
	localparam int          CMD_DIS_A_BIT = 6;
	localparam int          ODT_DIS_BIT   = 5;
	localparam int          CKE_MODE_BIT  = 4;
	localparam int          FREQ_LSB      = 2;
	localparam int          TYPE_LSB      = 0;

	// reset values
	localparam logic [2:0]  RATE_RST      = 3'h0;
	localparam logic [3:0]  HI_NIB_RST    = 4'h0;
	localparam logic [1:0]  FREQ_RST      = 2'h2;
	localparam logic [1:0]  TYPE_RST      = 2'h0;
	localparam logic [15:0] REMAP_RST     = 16'h8421;

	// refresh rate codes
	localparam logic [2:0]  RATE_OFF      = 3'h0;
	localparam logic [2:0]  RATE_15P6     = 3'h1;
	localparam logic [2:0]  RATE_7P8      = 3'h2;
	localparam logic [2:0]  RATE_64       = 3'h3;
	localparam logic [2:0]  RATE_3P9      = 3'h4;
	localparam logic [2:0]  RATE_FAST     = 3'h7;

	// memory type codes
	localparam logic [1:0]  MT_DDR266     = 2'h0;
	localparam logic [1:0]  MT_DDR333     = 2'h1;
	localparam logic [1:0]  MT_DDR2_400   = 2'h2;

	// refresh timing at the 100 ns clock
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          REF_15P6_NS   = 15600;
	localparam int          REF_7P8_NS    = 7800;
	localparam int          REF_64_NS     = 64000;
	localparam int          REF_3P9_NS    = 3900;
	localparam int          REF_FAST_CLKS = 64;
	localparam int          REF_CNT_W     = 10;
	localparam logic [REF_CNT_W-1:0] REF_15P6_CYC =
		REF_CNT_W'(REF_15P6_NS / CLK_PERIOD_NS);
	localparam logic [REF_CNT_W-1:0] REF_7P8_CYC =
		REF_CNT_W'(REF_7P8_NS / CLK_PERIOD_NS);
	localparam logic [REF_CNT_W-1:0] REF_64_CYC =
		REF_CNT_W'(REF_64_NS / CLK_PERIOD_NS);
	localparam logic [REF_CNT_W-1:0] REF_3P9_CYC =
		REF_CNT_W'(REF_3P9_NS / CLK_PERIOD_NS);
	localparam logic [REF_CNT_W-1:0] REF_FAST_CYC =
		REF_CNT_W'(REF_FAST_CLKS);

endpackage

// ---- src/dmcfg_if.sv ----
// links the config top to its refresh timer and chip-select mapper
`timescale 1ns/1ps
interface dmcfg_if;
	logic [2:0]  rate;
	logic        tick;
	logic [15:0] remap;
	logic [7:0]  log_cs_n;
	logic [7:0]  phy_cs_n;

	modport refr (input rate, output tick);
	modport map  (input remap, input log_cs_n, output phy_cs_n);
	modport ctl  (output rate, output remap, output log_cs_n,
		input tick, input phy_cs_n);
endinterface

// ---- src/dmcfg_refresh.sv ----
// refresh interval timer driven by the refresh rate select code
`timescale 1ns/1ps
module dmcfg_refresh (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the top
	dmcfg_if.refr     r
);
	import dmcfg_pkg::*;

	typedef struct packed {
		logic [2:0]           rate;
		logic [REF_CNT_W-1:0] cnt;
	} dmcfg_refst_t;

	dmcfg_refst_t          s_r;
	dmcfg_refst_t          s_nxt;
	logic [REF_CNT_W-1:0]  lim;

	always_comb begin
		unique case (r.rate)
			RATE_15P6: lim = REF_15P6_CYC;
			RATE_7P8:  lim = REF_7P8_CYC;
			RATE_64:   lim = REF_64_CYC;
			RATE_3P9:  lim = REF_3P9_CYC;
			RATE_FAST: lim = REF_FAST_CYC;
			default:   lim = '0;
		endcase
	end

	always_comb begin
		s_nxt      = s_r;
		s_nxt.rate = r.rate;
		if (lim == '0 || r.rate != s_r.rate || s_r.cnt == lim - 1'b1)
			s_nxt.cnt = '0;
		else
			s_nxt.cnt = s_r.cnt + 1'b1;
		if (rst_i) begin
			s_nxt.rate = RATE_OFF;
			s_nxt.cnt  = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign r.tick = (lim != '0) && (r.rate == s_r.rate)
		&& (s_r.cnt == lim - 1'b1);

	ref_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(lim != '0) && (r.rate == s_r.rate) |-> (s_r.cnt < lim))
		else $error("refresh count beyond interval");

	fast_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(r.tick && r.rate == RATE_FAST) |-> (s_r.cnt == 10'h03f))
		else $error("fast refresh tick not at 64 clocks");

endmodule // dmcfg_refresh

// ---- src/dmcfg_csmap.sv ----
// logical to physical chip-select pair remapping
`timescale 1ns/1ps
module dmcfg_csmap (
	// clock and reset, checks only
	input  wire logic clk_i,
	input  wire logic rst_i,
	// link to the top
	dmcfg_if.map      m
);
	import dmcfg_pkg::*;

	for (genvar p = 0; p < 4; p++) begin : g_pair
		logic [3:0] code;
		assign code = m.remap[4*p+3:4*p];
		always_comb begin
			unique case (code)
				4'h1:    m.phy_cs_n[2*p+1:2*p] = m.log_cs_n[1:0];
				4'h2:    m.phy_cs_n[2*p+1:2*p] = m.log_cs_n[3:2];
				4'h4:    m.phy_cs_n[2*p+1:2*p] = m.log_cs_n[5:4];
				4'h8:    m.phy_cs_n[2*p+1:2*p] = m.log_cs_n[7:6];
				default: m.phy_cs_n[2*p+1:2*p] = 2'h3;
			endcase
		end
	end

	pair1_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(m.remap[7:4] == 4'h2) |-> (m.phy_cs_n[3:2] == m.log_cs_n[3:2]))
		else $error("pair 3:2 not fed from logical 3:2");

	bad_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$onehot(m.remap[3:0]) |-> (m.phy_cs_n[1:0] == 2'h3))
		else $error("unsupported code drives pair 1:0");

endmodule // dmcfg_csmap

// ---- src/dmcfg_top.sv ----
// dram mode and chip-select config registers with wishbone slave
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps

module dmcfg_top (
	// clock and resets
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire logic                     por_i,
	// wishbone slave
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [dmcfg_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic      [31:0]              wb_dat_o,
	output logic                          wb_ack_o,
	// controller side inputs
	input  wire logic [7:0]               log_cs_n_i,
	input  wire logic [7:0]               odt_req_i,
	input  wire logic [7:0]               row_cke_i,
	input  wire logic [7:0]               slot_cke_i,
	// memory side outputs
	output logic                          refresh_req_o,
	output logic                          cmd_en_a_o,
	output logic                          cmd_en_b_o,
	output logic [7:0]                    cke_o,
	output logic [7:0]                    term_cs_o,
	output logic [7:0]                    phy_cs_n_o,
	output logic                          diff_strobe_o,
	output logic [1:0]                    host_bus_freq_select_o,
	output logic [1:0]                    memory_type_select_o
);
	import dmcfg_pkg::*;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
		logic [2:0]  rate;
		logic [3:0]  hi_nib;
		logic [1:0]  freq;
		logic [1:0]  mtype;
		logic        locked;
		logic [15:0] remap;
		logic        ref_pulse;
		logic        cmd_en_a;
		logic        cmd_en_b;
		logic [7:0]  cke;
		logic [7:0]  term;
		logic [7:0]  cs_n;
		logic        dqs_diff;
	} dmcfg_state_t;

	dmcfg_state_t s_r;
	dmcfg_state_t s_nxt;
	dmcfg_if      lnk ();
	logic         req;
	logic         hit_mode;
	logic         hit_remap;
	logic         wr_go;
	logic [31:0]  mode_word;
	logic         ddr2;
	logic         odt_off;
	logic         any_rst;

	// either reset clears the timer and quiets the checks
	assign any_rst = rst_i || por_i;

	dmcfg_refresh u_refresh (
		.clk_i (clk_i),
		.rst_i (any_rst),
		.r     (lnk.refr)
	);

	dmcfg_csmap u_csmap (
		.clk_i (clk_i),
		.rst_i (any_rst),
		.m     (lnk.map)
	);

	assign lnk.rate     = s_r.rate;
	assign lnk.remap    = s_r.remap;
	assign lnk.log_cs_n = log_cs_n_i;

	assign req       = wb_cyc_i && wb_stb_i;
	assign hit_mode  = (wb_adr_i == ADR_MODE);
	assign hit_remap = (wb_adr_i == ADR_REMAP);
	// write lands at the edge where ack is high
	assign wr_go     = req && wb_we_i && s_r.ack && !rst_i;

	assign mode_word = {21'h00_0000, s_r.rate, s_r.hi_nib,
		s_r.freq, s_r.mtype};

	assign ddr2    = (s_r.mtype == MT_DDR2_400);
	assign odt_off = s_r.hi_nib[ODT_DIS_BIT-4] && ddr2;

	always_comb begin
		s_nxt = s_r;

		// bus answer one cycle after the request
		s_nxt.ack = req && !s_r.ack;
		if (req && !s_r.ack) begin
			if (hit_mode)
				s_nxt.dat = mode_word;
			else if (hit_remap)
				s_nxt.dat = {16'h0000, s_r.remap};
			else
				s_nxt.dat = 32'h0000_0000;
		end

		if (wr_go && hit_mode) begin
			if (wb_sel_i[1])
				s_nxt.rate = wb_dat_i[RATE_LSB+2:RATE_LSB];
			if (wb_sel_i[0]) begin
				s_nxt.hi_nib = wb_dat_i[7:4];
				if (!s_r.locked) begin
					s_nxt.freq   = wb_dat_i[FREQ_LSB+1:FREQ_LSB];
					s_nxt.mtype  = wb_dat_i[TYPE_LSB+1:TYPE_LSB];
					s_nxt.locked = 1'b1;
				end
			end
		end

		// mapping fields written per byte lane
		if (wr_go && hit_remap) begin
			if (wb_sel_i[0])
				s_nxt.remap[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1])
				s_nxt.remap[15:8] = wb_dat_i[15:8];
		end

		// refresh request from the interval timer
		s_nxt.ref_pulse = lnk.tick;

		s_nxt.cmd_en_a = !s_r.hi_nib[CMD_DIS_A_BIT-4];
		s_nxt.cmd_en_b = !s_r.hi_nib[CMD_DIS_B_BIT-4];

		if (!s_r.hi_nib[CKE_MODE_BIT-4]) begin
			s_nxt.cke = row_cke_i;
		end else begin
			// per slot, gated by the owning channel
			for (int i = 0; i < 8; i++) begin
				if (i % 2 == 0)
					s_nxt.cke[i] = slot_cke_i[i] && s_nxt.cmd_en_a;
				else
					s_nxt.cke[i] = slot_cke_i[i] && s_nxt.cmd_en_b;
			end
		end

		// pins low until the type is set
		if (!s_r.locked)
			s_nxt.term = 8'h00;
		else if (ddr2)
			s_nxt.term = odt_off ? 8'h00 : odt_req_i;
		else
			s_nxt.term = ~lnk.phy_cs_n;

		s_nxt.cs_n = lnk.phy_cs_n;

		// warm reset keeps the sticky fields
		if (rst_i) begin
			s_nxt.ack       = 1'b0;
			s_nxt.dat       = 32'h0000_0000;
			s_nxt.rate      = RATE_RST;
			s_nxt.ref_pulse = 1'b0;
			s_nxt.cke       = 8'h00;
			s_nxt.term      = 8'h00;
			s_nxt.cs_n      = 8'hff;
		end

		if (por_i) begin
			s_nxt.ack       = 1'b0;
			s_nxt.dat       = 32'h0000_0000;
			s_nxt.rate      = RATE_RST;
			s_nxt.hi_nib    = HI_NIB_RST;
			s_nxt.freq      = FREQ_RST;
			s_nxt.mtype     = TYPE_RST;
			s_nxt.locked    = 1'b0;
			s_nxt.remap     = REMAP_RST;
			s_nxt.ref_pulse = 1'b0;
			s_nxt.cmd_en_a  = 1'b1;
			s_nxt.cmd_en_b  = 1'b1;
			s_nxt.cke       = 8'h00;
			s_nxt.term      = 8'h00;
			s_nxt.cs_n      = 8'hff;
		end

		s_nxt.dqs_diff = (s_nxt.mtype == MT_DDR2_400);
	end

	always_ff @(posedge clk_i) begin
		s_r <= s_nxt;
	end

	assign wb_ack_o               = s_r.ack;
	assign wb_dat_o               = s_r.dat;
	assign refresh_req_o          = s_r.ref_pulse;
	assign cmd_en_a_o             = s_r.cmd_en_a;
	assign cmd_en_b_o             = s_r.cmd_en_b;
	assign cke_o                  = s_r.cke;
	assign term_cs_o              = s_r.term;
	assign phy_cs_n_o             = s_r.cs_n;
	assign diff_strobe_o          = s_r.dqs_diff;
	assign host_bus_freq_select_o = s_r.freq;
	assign memory_type_select_o   = s_r.mtype;

	ack_timing_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle after request");

	nibble_lock_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.locked && wr_go && hit_mode)
		|=> $stable(host_bus_freq_select_o)
		&& $stable(memory_type_select_o))
		else $error("locked nibble changed by a write");

	first_lock_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(!s_r.locked && wr_go && hit_mode && wb_sel_i[0])
		|=> host_bus_freq_select_o == $past(wb_dat_i[3:2]))
		else $error("first write did not set frequency");

	pins_low_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		!s_r.locked |=> (term_cs_o == 8'h00))
		else $error("shared pins driven before type set");

	cmd_b_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		s_r.hi_nib[3] |=> !cmd_en_b_o)
		else $error("second command bus not stopped");

	cmd_a_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		!s_r.hi_nib[2] |=> cmd_en_a_o)
		else $error("first command bus stopped while enabled");

	odt_off_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.locked && ddr2 && s_r.hi_nib[1]) |=> (term_cs_o == 8'h00))
		else $error("termination driven while disabled");

	cke_shared_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		!s_r.hi_nib[0] |=> (cke_o == $past(row_cke_i)))
		else $error("shared enables do not follow rows");

	cke_slot_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.hi_nib[0] && s_r.hi_nib[2]) |=> (cke_o[0] == 1'b0))
		else $error("slot 0 enabled with first channel off");

	remap_keep_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		rst_i |=> $stable(s_r.remap))
		else $error("mapping lost on warm reset");

	ref_off_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.rate == RATE_OFF) |=> !refresh_req_o)
		else $error("refresh issued while disabled");

	ack_drop_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus answer held beyond one cycle");

	unmapped_read_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(req && !wb_ack_o && !hit_mode && !hit_remap)
		|=> (wb_dat_o == 32'h0000_0000))
		else $error("unmapped read returned data");

	rate_write_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(wr_go && hit_mode && wb_sel_i[1])
		|=> (s_r.rate == $past(wb_dat_i[RATE_LSB+2:RATE_LSB])))
		else $error("rate field not taken from write");

	remap_write_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(wr_go && hit_remap && wb_sel_i[1])
		|=> (s_r.remap[15:8] == $past(wb_dat_i[15:8])))
		else $error("upper mapping fields not written");

	rate_warm_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		rst_i |=> (s_r.rate == RATE_RST))
		else $error("rate field kept through warm reset");

	type_keep_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		rst_i |=> ($stable(memory_type_select_o)
		&& $stable(host_bus_freq_select_o)))
		else $error("type or frequency lost on warm reset");

	nib_keep_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		rst_i |=> $stable(s_r.hi_nib))
		else $error("sticky control bits lost on warm reset");

	lock_keep_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		s_r.locked |=> s_r.locked)
		else $error("lock released without power-on");

	cmd_b_on_a: assert property (@(posedge clk_i)
		disable iff (por_i)
		!s_r.hi_nib[3] |=> cmd_en_b_o)
		else $error("second command bus stopped while enabled");

	slot_b_off_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.hi_nib[0] && s_r.hi_nib[3]) |=> (cke_o[1] == 1'b0))
		else $error("slot 1 enabled with second channel off");

	term_ddr_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		(s_r.locked && !ddr2) |=> (term_cs_o == ~$past(lnk.phy_cs_n)))
		else $error("shared pins not chip selects in DDR");

	ref_single_a: assert property (@(posedge clk_i)
		disable iff (rst_i || por_i)
		refresh_req_o |=> !refresh_req_o)
		else $error("refresh request longer than one cycle");

endmodule // dmcfg_top

// ---- bench/dmcfg_dimm_model.sv ----
// memory-side partner that watches the refresh requests
`timescale 1ns/1ps
module dmcfg_dimm_model (
	// clock
	input  wire logic        clk_i,
	// from the controller
	input  wire logic        refresh_req_i,
	// observations
	output logic      [15:0] ref_cnt_o,
	output logic      [15:0] ref_gap_o
);
	logic [15:0] since_r;

	initial begin
		ref_cnt_o = 16'h0000;
		ref_gap_o = 16'h0000;
		since_r   = 16'h0000;
	end

	always @(posedge clk_i) begin
		since_r <= since_r + 16'h0001;
		if (refresh_req_i === 1'b1) begin
			ref_cnt_o <= ref_cnt_o + 16'h0001;
			ref_gap_o <= since_r + 16'h0001;
			since_r   <= 16'h0000;
		end
	end
endmodule // dmcfg_dimm_model

// ---- bench/dmcfg_tb_top.sv ----
// self-checking bench for the dram mode and chip-select config block
`timescale 1ns/1ps
module dmcfg_tb_top;
	import dmcfg_pkg::*;
	logic        clk_i, rst_i, por_i, cyc, stb, we, ack, rq;
	logic        en_a, en_b, diff;
	logic [7:0]  adr, log_cs_n, odt, row, slot, cke, term, phy;
	logic [3:0]  sel;
	logic [1:0]  freq, mtype;
	logic [31:0] dat, dat_o, rd;
	logic [15:0] ref_cnt, ref_gap;
	int          err_total, n_checks, cyc_cnt;

	dmcfg_top dmcfg_top_i (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.log_cs_n_i(log_cs_n), .odt_req_i(odt), .row_cke_i(row),
		.slot_cke_i(slot), .refresh_req_o(rq), .cmd_en_a_o(en_a),
		.cmd_en_b_o(en_b), .cke_o(cke), .term_cs_o(term),
		.phy_cs_n_o(phy), .diff_strobe_o(diff),
		.host_bus_freq_select_o(freq), .memory_type_select_o(mtype));

	dmcfg_dimm_model dmcfg_dimm_model_i (.clk_i(clk_i),
		.refresh_req_i(rq), .ref_cnt_o(ref_cnt), .ref_gap_o(ref_gap));

	task automatic end_of_test();
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		chk(n, 2);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 4'hf, 32'h0000_0000);
		chk(rd, exp);
	endtask

	task automatic reset(input logic full);
		@(posedge clk_i);
		por_i <= full;
		rst_i <= 1'b1;
		wt(4);
		por_i <= 1'b0;
		rst_i <= 1'b0;
	endtask

	task automatic t_rate(input logic [2:0] c, input int gap);
		logic [15:0] c0;
		int n;
		wb(1'b1, ADR_MODE, 4'h2, {21'h0, c, 8'h00});
		wt(3);
		c0 = ref_cnt;
		n = 0;
		while (ref_cnt - c0 < 16'h0002 && n < 1400) begin
			@(posedge clk_i);
			n++;
		end
		if (gap == 0)
			chk(ref_cnt - c0, 32'h0000_0000);
		else
			chk(ref_gap, gap);
	endtask

	// defaults after power-on
	task automatic t_defaults();
		wt(2);
		chk(term, 8'h00);
		chk({en_a, en_b, diff, freq, mtype}, 7'b1101000);
		rdchk(ADR_MODE, 32'h0000_0008);
		rdchk(ADR_REMAP, 32'h0000_8421);
		rdchk(8'h90, 32'h0000_0000);
	endtask

	// first low byte write locks type and frequency
	task automatic t_lock();
		wb(1'b1, ADR_MODE, 4'h1, 32'h0000_00be);
		wt(3);
		chk({en_a, en_b, diff, freq, mtype}, 7'b1011110);
		chk(term, 8'h00);
		chk(cke, 8'h55);
		wb(1'b1, ADR_MODE, 4'h1, 32'h0000_0001);
		wt(3);
		rdchk(ADR_MODE, 32'h0000_000e);
		chk(cke, row);
		chk(term, odt);
		chk({en_a, en_b}, 2'b11);
	endtask

	// warm reset keeps the sticky fields
	task automatic t_warm();
		wb(1'b1, ADR_MODE, 4'h3, 32'h0000_02f3);
		wb(1'b1, ADR_REMAP, 4'h3, 32'h0000_1248);
		reset(1'b0);
		rdchk(ADR_MODE, 32'h0000_00fe);
		rdchk(ADR_REMAP, 32'h0000_1248);
		chk({en_a, en_b}, 2'b00);
		chk(cke, 8'h00);
	endtask

	// logical to physical pair remapping
	task automatic t_remap();
		logic [7:0] ex;
		for (int i = 0; i < 4; i++) begin
			log_cs_n <= ~(8'h03 << (2 * i));
			ex = ~(8'h03 << (2 * (3 - i)));
			wt(3);
			chk(phy, ex);
		end
		wb(1'b1, ADR_REMAP, 4'h1, 32'h0000_0023);
		log_cs_n <= 8'hf3;
		wt(3);
		chk(phy, 8'hc3);
	endtask

	// every refresh code in turn
	task automatic t_rates();
		t_rate(3'h1, 156);
		t_rate(3'h2, 78);
		t_rate(3'h3, 640);
		t_rate(3'h4, 39);
		t_rate(3'h7, 64);
		t_rate(3'h0, 0);
		t_rate(3'h5, 0);
		t_rate(3'h6, 0);
	endtask

	// DDR type after a fresh power-on
	task automatic t_ddr();
		reset(1'b1);
		log_cs_n <= 8'hf0;
		wb(1'b1, ADR_MODE, 4'h1, 32'h0000_0025);
		wt(3);
		chk({diff, freq, mtype}, 5'b00101);
		chk(term, 8'h0f);
		chk({en_a, en_b}, 2'b11);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			err_total++;
			end_of_test();
		end
	end

	initial begin
		{cyc, stb, we, adr, sel, dat} = '0;
		{err_total, n_checks, cyc_cnt} = '0;
		por_i = 1'b1;
		rst_i = 1'b1;
		log_cs_n = 8'h00;
		odt = 8'h3c;
		row = 8'ha5;
		slot = 8'hff;
		reset(1'b1);
		t_defaults();
		t_lock();
		t_warm();
		t_remap();
		t_rates();
		t_ddr();
		end_of_test();
	end
endmodule // dmcfg_tb_top
